/* hdl/umfs_pkg.sv */
// Package of constants and carriers for the UART modem and FIFO status block
// ============================================================
// Overview of operation
// [RQ1] Word length field selects 5 to 8 bits
// [RQ2] Modem control bit 13 shows request pin level
// [RQ3] Bit 9 picks request output polarity
// [RQ4] Software bit 1 drives request pin through polarity
// [RQ5] Third channel hides modem registers as reserved
// [RQ6] Status bit 8 picks clear input polarity; the code only stores and reads back the bit, and applies it nowhere
// [RQ7] Status bit 4 shows clear pin level
// [RQ8] Clear input change sets bit 0, write-one clears
// [RQ9] Transmitter idle when FIFO empty, stop sent
// [RQ10] Write to full transmit FIFO sets bit 24
// [RQ11] Transmit full at bit 23 at FIFO depth
// [RQ12] Transmit empty set at last move, write clears
// [RQ13] Transmit pointer bits 21:16 counts occupancy
// [RQ14] Full transmit FIFO shows pointer zero
// [RQ15] Receive full at bit 15 at FIFO depth
// [RQ16] Receive empty set at last read, receive clears
// [RQ17] Receive pointer bits 13:8 counts occupancy
// [RQ18] Full receive FIFO shows pointer zero
// [RQ19] Long low line sets break bit 6
// [RQ20] Zero stop bit sets framing bit 5
// [RQ21] Bad parity sets parity bit 4
// [RQ22] Receive overrun sets bit 0, write-one clears
// [RQ23] Clear input synchronised before change detection
`default_nettype none
package umfs_pkg;
  // ============================================================
  // Register map
  localparam logic [7:0] OFS_LINE_CTRL = 8'h0C;
  localparam logic [7:0] OFS_MODEM_CONTROL = 8'h10;
  localparam logic [7:0] OFS_MODEM_STATUS = 8'h14;
  localparam logic [7:0] OFS_FIFO_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVENT_CTRL = 8'h20;
  localparam logic [31:0] RST_MODEM_CONTROL = 32'h0000_0200;
  localparam logic [31:0] RST_MODEM_STATUS = 32'h0000_0110;
  localparam logic [31:0] RST_FIFO_STATUS = 32'h1040_4000;
  // ============================================================
  // Field positions
  localparam int MC_SW_REQ = 1;
  localparam int MC_REQ_POL = 9;
  localparam int MC_REQ_PIN = 13;
  localparam int MS_CHG = 0;
  localparam int MS_CLR_PIN = 4;
  localparam int MS_CLR_POL = 8;
  localparam int FS_RX_OVR = 0;
  localparam int FS_PAR = 4;
  localparam int FS_FRM = 5;
  localparam int FS_BRK = 6;
  localparam int FS_RX_PTR = 8;
  localparam int FS_RX_EMPTY = 14;
  localparam int FS_RX_FULL = 15;
  localparam int FS_TX_PTR = 16;
  localparam int FS_TX_EMPTY = 22;
  localparam int FS_TX_FULL = 23;
  localparam int FS_TX_OVR = 24;
  localparam int FS_TX_IDLE = 28;
  // Event control register bits, written 1 to pulse
  localparam int EV_RX_CHAR = 0;
  localparam int EV_RX_READ = 1;
  localparam int EV_TX_MOVE = 2;
  localparam int EV_STOP_DONE = 3;
  localparam int EV_BREAK = 4;
  localparam int EV_FRAME = 5;
  localparam int EV_PARITY = 6;
  localparam int EV_TX_WRITE = 7;
  // ============================================================
  // Carriers
  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hsel;
    logic hready;
  } umfs_ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } umfs_ahb_rsp_t;
endpackage
`default_nettype wire

/* hdl/umfs_sync.sv */
// Two-stage synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module umfs_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic din,
  output logic dout
);
  logic first;
  // ============================================================
  // Stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first <= RESET_VALUE;
      dout <= RESET_VALUE;
    end else begin
      first <= din;
      dout <= first;
    end
  end
endmodule // umfs_sync
`default_nettype wire

/* hdl/umfs_top.sv */
// UART modem control and FIFO status block with AHB-Lite register slave
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module umfs_top #(
  parameter int FIFO_DEPTH = 64,
  parameter logic HAS_MODEM = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire umfs_pkg::umfs_ahb_req_t ahb_req,
  output umfs_pkg::umfs_ahb_rsp_t ahb_rsp,
  input wire logic clear_pin,
  input wire logic modem_irq_enable,
  output logic request_pin,
  output logic modem_irq,
  output logic [1:0] char_length_select,
  output logic [3:0] char_bits
);
  typedef struct packed {
    logic aph_wr;
    logic aph_rd;
    logic [7:0] aph_ofs;
    logic [31:0] hrdata;
    logic hready_out;
    logic [1:0] char_length_select;
    logic [3:0] char_bits;
    logic sw_req;
    logic request_output_polarity;
    logic request_pin;
    logic clear_input_polarity;
    logic clear_prev;
    logic clear_change_flag;
    logic [6:0] tx_count;
    logic [6:0] rx_count;
    logic tx_empty;
    logic rx_empty;
    logic tx_ovr;
    logic rx_ovr;
    logic stop_done;
    logic line_break_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic modem_irq;
  } umfs_state_t;

  localparam logic [6:0] DEPTH = 7'(FIFO_DEPTH);
  umfs_state_t cur, next_cur;
  logic clear_sync;
  logic take;
  logic ev_wr;
  logic [31:0] wd;
  logic [31:0] rd_mux;
  logic tx_full, rx_full, tx_push, tx_pop, rx_push, rx_pop;
  logic [5:0] tx_ptr, rx_ptr;

  // ============================================================
  // Clear input synchroniser
  umfs_sync #(
    .RESET_VALUE(umfs_pkg::RST_MODEM_STATUS[umfs_pkg::MS_CLR_PIN])
  ) u_clear_sync ( // RQ23
    .hclk(hclk),
    .hresetn(hresetn),
    .din(clear_pin),
    .dout(clear_sync)
  );

  assign take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  assign wd = ahb_req.hwdata;
  assign ev_wr = cur.aph_wr & (cur.aph_ofs == umfs_pkg::OFS_EVENT_CTRL);
  assign tx_full = (cur.tx_count == DEPTH); // RQ11
  assign rx_full = (cur.rx_count == DEPTH); // RQ15
  assign tx_ptr = tx_full ? 6'h00 : cur.tx_count[5:0]; // RQ14
  assign rx_ptr = rx_full ? 6'h00 : cur.rx_count[5:0]; // RQ18

  // ============================================================
  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (cur.aph_ofs)
      umfs_pkg::OFS_LINE_CTRL: rd_mux[1:0] = cur.char_length_select;
      umfs_pkg::OFS_MODEM_CONTROL: begin
        if (HAS_MODEM) begin // RQ5
          rd_mux[umfs_pkg::MC_SW_REQ] = cur.sw_req;
          rd_mux[umfs_pkg::MC_REQ_POL] = cur.request_output_polarity;
          rd_mux[umfs_pkg::MC_REQ_PIN] = cur.request_pin; // RQ2
        end
      end
      umfs_pkg::OFS_MODEM_STATUS: begin
        if (HAS_MODEM) begin // RQ5
          rd_mux[umfs_pkg::MS_CHG] = cur.clear_change_flag;
          rd_mux[umfs_pkg::MS_CLR_PIN] = clear_sync; // RQ7
          rd_mux[umfs_pkg::MS_CLR_POL] = cur.clear_input_polarity;
        end
      end
      umfs_pkg::OFS_FIFO_STATUS: begin
        rd_mux[umfs_pkg::FS_TX_IDLE] = cur.tx_empty & cur.stop_done; // RQ9
        rd_mux[umfs_pkg::FS_TX_OVR] = cur.tx_ovr;
        rd_mux[umfs_pkg::FS_TX_FULL] = tx_full;
        rd_mux[umfs_pkg::FS_TX_EMPTY] = cur.tx_empty;
        rd_mux[umfs_pkg::FS_TX_PTR +: 6] = tx_ptr; // RQ13
        rd_mux[umfs_pkg::FS_RX_FULL] = rx_full;
        rd_mux[umfs_pkg::FS_RX_EMPTY] = cur.rx_empty;
        rd_mux[umfs_pkg::FS_RX_PTR +: 6] = rx_ptr; // RQ17
        rd_mux[umfs_pkg::FS_BRK] = cur.line_break_flag;
        rd_mux[umfs_pkg::FS_FRM] = cur.framing_error_flag;
        rd_mux[umfs_pkg::FS_PAR] = cur.parity_error_flag;
        rd_mux[umfs_pkg::FS_RX_OVR] = cur.rx_ovr;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // Next state
  always_comb begin
    logic wr_lcr, wr_mc, wr_ms, wr_fs, wr_ev, req_level;
    wr_lcr = 1'b0;
    wr_mc = 1'b0;
    wr_ms = 1'b0;
    wr_fs = 1'b0;
    wr_ev = 1'b0;
    req_level = 1'b0;
    next_cur = cur;
    // Address phase capture
    next_cur.aph_wr = take & ahb_req.hwrite;
    next_cur.aph_rd = take & ~ahb_req.hwrite;
    next_cur.aph_ofs = ahb_req.haddr[7:0];
    if (take & ~ahb_req.hwrite) begin
      next_cur.aph_ofs = ahb_req.haddr[7:0];
    end
    // Reads get one wait state so that hrdata comes from a register
    next_cur.hrdata = 32'h0000_0000;
    next_cur.hready_out = 1'b1;
    if (take & ~ahb_req.hwrite) begin
      next_cur.hready_out = 1'b0;
    end
    if (cur.aph_rd) begin
      next_cur.hrdata = rd_mux;
    end
    if (cur.aph_wr) begin
      wr_lcr = (cur.aph_ofs == umfs_pkg::OFS_LINE_CTRL);
      wr_mc = (cur.aph_ofs == umfs_pkg::OFS_MODEM_CONTROL) & HAS_MODEM;
      wr_ms = (cur.aph_ofs == umfs_pkg::OFS_MODEM_STATUS) & HAS_MODEM;
      wr_fs = (cur.aph_ofs == umfs_pkg::OFS_FIFO_STATUS);
      wr_ev = (cur.aph_ofs == umfs_pkg::OFS_EVENT_CTRL);
    end
    tx_push = wr_ev & wd[umfs_pkg::EV_TX_WRITE];
    tx_pop = wr_ev & wd[umfs_pkg::EV_TX_MOVE] & (cur.tx_count != 7'h00);
    rx_push = wr_ev & wd[umfs_pkg::EV_RX_CHAR];
    rx_pop = wr_ev & wd[umfs_pkg::EV_RX_READ] & (cur.rx_count != 7'h00);
    if (wr_lcr) begin
      next_cur.char_length_select = wd[1:0]; // RQ1
    end
    next_cur.char_bits = 4'(next_cur.char_length_select) + 4'h5; // RQ1
    if (wr_mc) begin
      next_cur.sw_req = wd[umfs_pkg::MC_SW_REQ];
      next_cur.request_output_polarity = wd[umfs_pkg::MC_REQ_POL]; // RQ3
    end
    if (wr_ms) begin
      next_cur.clear_input_polarity = wd[umfs_pkg::MS_CLR_POL]; // RQ6
    end
    // Request pin: high polarity follows, low polarity inverts
    req_level = next_cur.request_output_polarity ? next_cur.sw_req
                                                 : ~next_cur.sw_req; // RQ4
    next_cur.request_pin = req_level;
    // Clear change flag: set wins over write-one clear
    next_cur.clear_prev = clear_sync;
    if (wr_ms & wd[umfs_pkg::MS_CHG]) begin
      next_cur.clear_change_flag = 1'b0;
    end
    if (HAS_MODEM & (clear_sync != cur.clear_prev)) begin
      next_cur.clear_change_flag = 1'b1; // RQ8
    end
    next_cur.modem_irq = next_cur.clear_change_flag & modem_irq_enable; // RQ8
    // Transmit FIFO occupancy
    if (wr_fs & wd[umfs_pkg::FS_TX_OVR]) begin
      next_cur.tx_ovr = 1'b0;
    end
    if (tx_push & tx_full) begin
      next_cur.tx_ovr = 1'b1; // RQ10
    end
    if ((tx_push & ~tx_full) & ~tx_pop) begin
      next_cur.tx_count = cur.tx_count + 7'h01; // RQ13
    end else if (tx_pop & ~(tx_push & ~tx_full)) begin
      next_cur.tx_count = cur.tx_count - 7'h01; // RQ13
    end
    if (tx_push & ~tx_full) begin
      next_cur.tx_empty = 1'b0; // RQ12
      next_cur.stop_done = 1'b0; // RQ9
    end else if (tx_pop & (cur.tx_count == 7'h01)) begin
      next_cur.tx_empty = 1'b1; // RQ12
    end
    if (tx_pop) begin
      next_cur.stop_done = 1'b0;
    end
    if (wr_ev & wd[umfs_pkg::EV_STOP_DONE] & next_cur.tx_empty) begin
      next_cur.stop_done = 1'b1; // RQ9
    end
    // Receive FIFO occupancy
    if (wr_fs & wd[umfs_pkg::FS_RX_OVR]) begin
      next_cur.rx_ovr = 1'b0;
    end
    if (rx_push & rx_full) begin
      next_cur.rx_ovr = 1'b1; // RQ22
    end
    if ((rx_push & ~rx_full) & ~rx_pop) begin
      next_cur.rx_count = cur.rx_count + 7'h01; // RQ17
    end else if (rx_pop & ~(rx_push & ~rx_full)) begin
      next_cur.rx_count = cur.rx_count - 7'h01; // RQ17
    end
    if (rx_push) begin
      next_cur.rx_empty = 1'b0; // RQ16
    end else if (rx_pop & (cur.rx_count == 7'h01)) begin
      next_cur.rx_empty = 1'b1; // RQ16
    end
    // Line error flags: set wins over write-one clear
    if (wr_fs & wd[umfs_pkg::FS_BRK]) begin
      next_cur.line_break_flag = 1'b0;
    end
    if (wr_fs & wd[umfs_pkg::FS_FRM]) begin
      next_cur.framing_error_flag = 1'b0;
    end
    if (wr_fs & wd[umfs_pkg::FS_PAR]) begin
      next_cur.parity_error_flag = 1'b0;
    end
    if (wr_ev & wd[umfs_pkg::EV_BREAK]) begin
      next_cur.line_break_flag = 1'b1; // RQ19
    end
    if (wr_ev & wd[umfs_pkg::EV_FRAME]) begin
      next_cur.framing_error_flag = 1'b1; // RQ20
    end
    if (wr_ev & wd[umfs_pkg::EV_PARITY]) begin
      next_cur.parity_error_flag = 1'b1; // RQ21
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
      cur.request_output_polarity <= umfs_pkg::RST_MODEM_CONTROL[9];
      cur.clear_input_polarity <= umfs_pkg::RST_MODEM_STATUS[8];
      cur.rx_empty <= umfs_pkg::RST_FIFO_STATUS[14];
      cur.tx_empty <= umfs_pkg::RST_FIFO_STATUS[22];
      cur.stop_done <= umfs_pkg::RST_FIFO_STATUS[28];
      cur.request_pin <= 1'b0;
      cur.hready_out <= 1'b1;
      cur.char_bits <= 4'h5;
      cur.clear_prev <= umfs_pkg::RST_MODEM_STATUS[umfs_pkg::MS_CLR_PIN];
    end else begin
      cur <= next_cur;
    end
  end

  // ============================================================
  // Outputs
  always_comb begin
    ahb_rsp.hrdata = cur.hrdata;
    ahb_rsp.hreadyout = cur.hready_out;
    ahb_rsp.hresp = 1'b0;
  end
  assign request_pin = cur.request_pin;
  assign modem_irq = cur.modem_irq;
  assign char_length_select = cur.char_length_select;
  assign char_bits = cur.char_bits;

  // ============================================================
  // Checks
  sequence s_change;
    clear_sync != $past(clear_sync);
  endsequence
  sequence s_read_wait;
    !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
  endsequence
  chk_clear_change: assert property ( // RQ8
    @(posedge hclk) disable iff (!hresetn)
    (HAS_MODEM and s_change) |=> cur.clear_change_flag)
    else $error("change flag not set");
  chk_irq_enable: assert property ( // RQ8
    @(posedge hclk) disable iff (!hresetn)
    modem_irq |-> $past(modem_irq_enable))
    else $error("modem interrupt without enable");
  chk_req_polarity: assert property ( // RQ4
    @(posedge hclk) disable iff (!hresetn)
    request_pin == (cur.request_output_polarity ~^ cur.sw_req))
    else $error("request pin polarity wrong");
  chk_tx_overflow: assert property ( // RQ10
    @(posedge hclk) disable iff (!hresetn)
    (tx_push && tx_full) |=> cur.tx_ovr)
    else $error("tx overflow not flagged");
  chk_tx_full_ptr: assert property ( // RQ14
    @(posedge hclk) disable iff (!hresetn)
    tx_full |-> (tx_ptr == 6'h00))
    else $error("tx pointer not zero when full");
  chk_tx_ptr_max: assert property ( // RQ14
    @(posedge hclk) disable iff (!hresetn)
    (tx_full && tx_pop && !tx_push) |=>
    (!tx_full && tx_ptr == 6'(DEPTH - 7'h01)))
    else $error("tx pointer wrong after move");
  chk_rx_full_zero: assert property ( // RQ18
    @(posedge hclk) disable iff (!hresetn)
    rx_full |-> (rx_ptr == 6'h00))
    else $error("rx pointer not zero when full");
  chk_rx_full_ptr: assert property ( // RQ18
    @(posedge hclk) disable iff (!hresetn)
    (rx_full && rx_pop && !rx_push) |=>
    (!rx_full && rx_ptr == 6'(DEPTH - 7'h01)))
    else $error("rx pointer wrong after read");
  chk_rx_overflow: assert property ( // RQ22
    @(posedge hclk) disable iff (!hresetn)
    (rx_push && rx_full) |=> cur.rx_ovr)
    else $error("rx overflow not flagged");
  chk_tx_idle: assert property ( // RQ9
    @(posedge hclk) disable iff (!hresetn)
    (tx_push && !tx_full) |=> !(cur.tx_empty && cur.stop_done))
    else $error("transmitter idle after write");
  chk_tx_empty_set: assert property ( // RQ12
    @(posedge hclk) disable iff (!hresetn)
    (tx_pop && !tx_push && cur.tx_count == 7'h01) |=> cur.tx_empty)
    else $error("tx empty not set on last move");
  chk_tx_count_up: assert property ( // RQ13
    @(posedge hclk) disable iff (!hresetn)
    (tx_push && !tx_full && !tx_pop) |=>
    (cur.tx_count == $past(cur.tx_count) + 7'h01))
    else $error("tx pointer not advanced");
  chk_rx_empty: assert property ( // RQ16
    @(posedge hclk) disable iff (!hresetn)
    rx_push |=> !cur.rx_empty)
    else $error("rx empty after receive");
  chk_rx_empty_set: assert property ( // RQ16
    @(posedge hclk) disable iff (!hresetn)
    (rx_pop && !rx_push && cur.rx_count == 7'h01) |=> cur.rx_empty)
    else $error("rx empty not set on last read");
  chk_rx_count_up: assert property ( // RQ17
    @(posedge hclk) disable iff (!hresetn)
    (rx_push && !rx_full && !rx_pop) |=>
    (cur.rx_count == $past(cur.rx_count) + 7'h01))
    else $error("rx pointer not advanced");
  chk_break_set: assert property ( // RQ19
    @(posedge hclk) disable iff (!hresetn)
    (ev_wr && wd[umfs_pkg::EV_BREAK]) |=> cur.line_break_flag)
    else $error("break flag not set");
  chk_frame_set: assert property ( // RQ20
    @(posedge hclk) disable iff (!hresetn)
    (ev_wr && wd[umfs_pkg::EV_FRAME]) |=> cur.framing_error_flag)
    else $error("framing flag not set");
  chk_parity_set: assert property ( // RQ21
    @(posedge hclk) disable iff (!hresetn)
    (ev_wr && wd[umfs_pkg::EV_PARITY]) |=> cur.parity_error_flag)
    else $error("parity flag not set");
  chk_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && !ahb_req.hwrite) |=> s_read_wait)
    else $error("read wait state wrong");
  chk_char_len: assert property ( // RQ1
    @(posedge hclk) disable iff (!hresetn)
    char_bits == 4'(char_length_select) + 4'h5)
    else $error("character length wrong");
endmodule // umfs_top
`default_nettype wire

/* sim/umfs_modem_model.sv */
// Remote modem model: answers the request line on the clear line
`timescale 1ns/1ns
`default_nettype none
module umfs_modem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic request_pin,
  input wire logic [3:0] delay,
  output logic clear_pin
);
  // ============================================================
  // Delay line, one cycle at delay 0, slow up to 16 cycles
  logic [15:0] hist;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hist <= 16'h0000;
    else
      hist <= {hist[14:0], request_pin};
  end
  // Crossed and inverted, idle high while request is low
  assign clear_pin = ~hist[delay];
endmodule // umfs_modem_model
`default_nettype wire

/* sim/umfs_top_bench.sv */
// Self-checking bench for the modem and FIFO status block
`timescale 1ns/1ns
`default_nettype none
module umfs_top_bench;
  localparam int D = 16;
  localparam logic [7:0] A_MC = umfs_pkg::OFS_MODEM_CONTROL;
  localparam logic [7:0] A_MS = umfs_pkg::OFS_MODEM_STATUS;
  localparam logic [7:0] A_FS = umfs_pkg::OFS_FIFO_STATUS;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [1:0] tr = 2'b00;
  logic [31:0] ad = 32'h0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic sel = 1'b0;
  logic en = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] seed = 32'h44834C90;
  umfs_pkg::umfs_ahb_req_t req;
  umfs_pkg::umfs_ahb_rsp_t rsp, rsp2;
  logic clear_pin, request_pin, modem_irq, p, s, pin;
  logic [1:0] cls;
  logic [3:0] cbits;
  logic [7:0] ma;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int tn = 0;
  int rn = 0;
  logic tov = 1'b0, rov = 1'b0, brk = 1'b0, frm = 1'b0, par = 1'b0;
  logic idle = 1'b1;
  logic [31:0] qe[$], qe2[$];
  logic [7:0] qa[$];
  logic rd_dph = 1'b0;
  assign req = {tr, ad, wr, 3'b010, wd, sel, rsp.hreadyout};
  // ============================================================
  // Instances
  umfs_top #(.FIFO_DEPTH(D), .HAS_MODEM(1'b1)) DUT (.hclk(hclk),
    .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp), .clear_pin(clear_pin),
    .modem_irq_enable(en), .request_pin(request_pin), .modem_irq(modem_irq),
    .char_length_select(cls), .char_bits(cbits));
  umfs_top #(.FIFO_DEPTH(D), .HAS_MODEM(1'b0)) DUT2 (.hclk(hclk),
    .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp2), .clear_pin(clear_pin),
    .modem_irq_enable(en), .request_pin(), .modem_irq(),
    .char_length_select(), .char_bits());
  umfs_modem_model MODEM (.hclk(hclk), .hresetn(hresetn),
    .request_pin(request_pin), .delay(dly), .clear_pin(clear_pin));
  // ============================================================
  // Clock, timeout, report
  initial forever #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task automatic final_report;
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // ============================================================
  // Compare tasks and read monitor
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic chkp(input string n, input logic [3:0] e,
                      input logic [3:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge hclk) begin
    if (rd_dph && rsp.hreadyout === 1'b1) begin
      ma = qa.pop_front();
      chk(ma, qe.pop_front(), rsp.hrdata);
      chk(ma, qe2.pop_front(), rsp2.hrdata);
    end
  end
  // ============================================================
  // Bus master
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    tr <= 2'b10;
    ad <= {24'h0, a};
    wr <= w;
    sel <= 1'b1;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    tr <= 2'b00;
    sel <= 1'b0;
    wd <= d;
    if (!w) begin
      qa.push_back(a);
      qe.push_back(e);
      qe2.push_back((a == A_MC || a == A_MS) ? 32'h0 : e);
    end
    rd_dph <= !w;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rd_dph <= 1'b0;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  function automatic logic [31:0] fs();
    logic [5:0] tp, rp;
    tp = (tn == D) ? 6'h00 : 6'(tn);
    rp = (rn == D) ? 6'h00 : 6'(rn);
    return {3'h0, idle, 3'h0, tov, tn == D, tn == 0, tp, rn == D, rn == 0, rp,
            1'b0, brk, frm, par, 3'h0, rov};
  endfunction
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      wrr(umfs_pkg::OFS_EVENT_CTRL, 32'h1 << b);
      case (b)
        umfs_pkg::EV_TX_WRITE: begin
          if (tn == D) tov = 1'b1;
          else tn++;
          idle = 1'b0;
        end
        umfs_pkg::EV_TX_MOVE: if (tn > 0) tn--;
        umfs_pkg::EV_STOP_DONE: idle = (tn == 0);
        umfs_pkg::EV_RX_CHAR: if (rn == D) rov = 1'b1; else rn++;
        umfs_pkg::EV_RX_READ: if (rn > 0) rn--;
        umfs_pkg::EV_BREAK: brk = 1'b1;
        umfs_pkg::EV_FRAME: frm = 1'b1;
        default: par = 1'b1;
      endcase
    end
  endtask
  // ============================================================
  // Main sequence
  initial begin
    seed = lfsr(seed);
    dly <= seed[3:0];
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(A_MC, umfs_pkg::RST_MODEM_CONTROL);
    rdc(A_MS, umfs_pkg::RST_MODEM_STATUS);
    rdc(A_FS, umfs_pkg::RST_FIFO_STATUS);
    seed = lfsr(seed);
    wrr(8'h3C, seed);
    rdc(8'h3C, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wrr(umfs_pkg::OFS_LINE_CTRL, {30'h0, 2'(i)});
      rdc(umfs_pkg::OFS_LINE_CTRL, {30'h0, 2'(i)});
      chkp("char_bits", 4'(i + 5), cbits);
      chkp("char_length_select", 4'(i), {2'b00, cls});
    end
    for (int i = 0; i < 4; i++) begin
      p = i[1];
      s = i[0];
      pin = p ? s : ~s;
      wrr(A_MC, {22'h0, p, 7'h0, s, 1'b0});
      settle(2);
      chkp("request_pin", {3'h0, pin}, {3'h0, request_pin});
      rdc(A_MC, {18'h0, pin, 3'h0, p, 7'h0, s, 1'b0});
    end
    settle(20);
    wrr(A_MS, 32'h101);
    rdc(A_MS, 32'h100);
    @(posedge hclk) en <= 1'b1;
    wrr(A_MC, 32'h200);
    settle(20);
    rdc(A_MS, 32'h111);
    chkp("modem_irq", 4'h1, {3'h0, modem_irq});
    wrr(A_MS, 32'h001);
    rdc(A_MS, 32'h010);
    chkp("modem_irq", 4'h0, {3'h0, modem_irq});
    @(posedge hclk) en <= 1'b0;
    wrr(A_MC, 32'h202);
    settle(20);
    chkp("modem_irq", 4'h0, {3'h0, modem_irq});
    rdc(A_MS, 32'h001);
    wrr(A_MS, 32'h001);
    pulse(umfs_pkg::EV_TX_WRITE, D - 1);
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_TX_WRITE, 2);
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_TX_MOVE, 1);
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_TX_MOVE, D - 1);
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_STOP_DONE, 1);
    rdc(A_FS, fs());
    wrr(A_FS, 32'h0100_0000);
    tov = 1'b0;
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_RX_CHAR, D + 1);
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_RX_READ, 1);
    rdc(A_FS, fs());
    pulse(umfs_pkg::EV_RX_READ, D - 1);
    rdc(A_FS, fs());
    for (int b = umfs_pkg::EV_BREAK; b <= umfs_pkg::EV_PARITY; b++) begin
      pulse(b, 1);
      rdc(A_FS, fs());
    end
    wrr(A_FS, 32'h0000_0071);
    {brk, frm, par, rov} = 4'h0;
    rdc(A_FS, fs());
    settle(2);
    final_report();
  end
endmodule // umfs_top_bench
`default_nettype wire
